// >>> verilog/mie_pkg.sv
// Shared constants and opcode set for the instruction execute core.
// Assumes a single 200 MHz clock and an APB master for status access.
package mie_pkg;

   localparam int PC_W = 11;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 5;

   // Reset values
   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam logic [7:0] WREG_RESET = 8'h00;
   localparam logic [1:0] CTRL_RESET = 2'h2;

   // Program counter steps
   localparam logic [PC_W-1:0] PC_STEP = 11'h001;
   localparam logic [PC_W-1:0] PC_SKIP = 11'h002;

   // Decimal adjust figures
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
   localparam logic [3:0] BCD_FIX = 4'h6;

   // Register offsets (byte addresses)
   localparam logic [11:0] ADDR_STATUS = 12'h000;
   localparam logic [11:0] ADDR_CTRL = 12'h004;

   // Control fields
   localparam int CTRL_WAKE_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;

   // Status fields
   localparam int ST_WREG_LSB = 0;
   localparam int ST_CARRY = 8;
   localparam int ST_HALF = 9;
   localparam int ST_ZERO = 10;
   localparam int ST_EXCESS = 11;
   localparam int ST_IRQEN = 12;
   localparam int ST_SLEEP = 13;
   localparam int ST_WDEXP = 14;
   localparam int ST_PC_LSB = 16;

   typedef enum logic [4:0] {
      OP_IDLE = 5'b00000,
      OP_BCD_ADJUST = 5'b00001,
      OP_MINUS1_MEM = 5'b00010,
      OP_MINUS1_WREG = 5'b00011,
      OP_PLUS1_MEM = 5'b00100,
      OP_PLUS1_WREG = 5'b00101,
      OP_POWER_DOWN = 5'b00110,
      OP_JUMP_ABS = 5'b00111,
      OP_COPY_M2W = 5'b01000,
      OP_COPY_I2W = 5'b01001,
      OP_COPY_W2M = 5'b01010,
      OP_UNION_MEM_W = 5'b01011,
      OP_UNION_IMM_W = 5'b01100,
      OP_UNION_TO_MEM = 5'b01101,
      OP_CALL_EXIT = 5'b01110,
      OP_CALL_EXIT_IMM = 5'b01111,
      OP_IRQ_EXIT = 5'b10000,
      OP_ROL_MEM = 5'b10001,
      OP_ROL_WREG = 5'b10010,
      OP_ROLC_MEM = 5'b10011,
      OP_ROLC_WREG = 5'b10100,
      OP_ROR_MEM = 5'b10101,
      OP_ROR_WREG = 5'b10110,
      OP_RORC_MEM = 5'b10111,
      OP_RORC_WREG = 5'b11000,
      OP_SUBB_WREG = 5'b11001,
      OP_SUBB_MEM = 5'b11010,
      OP_DSKIP_MEM = 5'b11011,
      OP_DSKIP_WREG = 5'b11100
   } mie_op_e;

endpackage : mie_pkg

// >>> verilog/mie_execute_core.sv
// Execute stage for one group of 8-bit core instructions, plus APB status.
// Assumes fetch offers one decoded instruction with its memory operand,
// memory and stack accept the registered write/pop strobes, all on clk_sys.
`timescale 1ns/1ps
module mie_execute_core (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clkEn,
   // Instruction offer
   input wire logic instValid,
   input wire mie_pkg::mie_op_e instOp,
   input wire logic [7:0] instImm,
   input wire logic [mie_pkg::PC_W-1:0] instTarget,
   input wire logic [7:0] memAddr,
   input wire logic [7:0] memRdData,
   input wire logic [mie_pkg::PC_W-1:0] stackTop,
   input wire logic irqPending,
   input wire logic wdtTimeout,
   output logic instReady,
   // Core state outputs
   output logic [mie_pkg::PC_W-1:0] pcOut,
   output logic [7:0] wregOut,
   output logic memWrEn,
   output logic [7:0] memWrAddr,
   output logic [7:0] memWrData,
   output logic stackPop,
   output logic irqServe,
   output logic dummySlot,
   output logic wdtClear,
   output logic clockStop,
   output logic carryFlag,
   output logic halfCarryFlag,
   output logic zeroFlag,
   output logic signedExcessFlag,
   output logic masterIrqEnable,
   output logic sleepFlag,
   output logic watchdogExpiredFlag,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   logic [mie_pkg::PC_W-1:0] pcReg, pcNext;
   logic [7:0] wregReg, wregNext;
   logic memWrEnReg, memWrEnNext;
   logic [7:0] memWrAddrReg, memWrAddrNext;
   logic [7:0] memWrDataReg, memWrDataNext;
   logic stackPopReg, stackPopNext;
   logic irqServeReg, irqServeNext;
   logic busyReg, busyNext;
   logic wdtClearReg, wdtClearNext;
   logic carryReg, carryNext;
   logic halfReg, halfNext;
   logic zeroReg, zeroNext;
   logic excessReg, excessNext;
   logic irqEnReg, irqEnNext;
   logic sleepReg, sleepNext;
   logic wdExpReg, wdExpNext;
   logic readyReg, readyNext;
   logic [1:0] ctrlReg, ctrlNext;
   logic [31:0] prdataReg, prdataNext;
   logic preadyReg, preadyNext;
   logic slverrReg, slverrNext;

   logic fire;
   logic wake;
   logic apbDone;
   logic loAdj, hiAdj;
   logic [7:0] bcdCorr;
   logic [8:0] bcdSum;
   logic [8:0] diff9;
   logic [4:0] diffLo;
   logic [7:0] minus1, plus1;

   assign fire = clkEn && instValid && readyReg;
   assign apbDone = psel && penable && preadyReg;
   assign wake = apbDone && pwrite && (paddr == mie_pkg::ADDR_CTRL)
                 && pwdata[mie_pkg::CTRL_WAKE_BIT];

   // Nibble conditions are taken on the byte before any correction
   assign loAdj = (wregReg[3:0] > mie_pkg::BCD_MAX_DIGIT) || halfReg;
   assign hiAdj = (wregReg[7:4] > mie_pkg::BCD_MAX_DIGIT) || carryReg;
   assign bcdCorr = {hiAdj ? mie_pkg::BCD_FIX : 4'h0, loAdj ? mie_pkg::BCD_FIX : 4'h0};
   assign bcdSum = {1'b0, wregReg} + {1'b0, bcdCorr};
   // Borrow-style subtract; top bit set means negative result
   assign diff9 = {1'b0, wregReg} - {1'b0, memRdData} - {8'h00, ~carryReg};
   assign diffLo = {1'b0, wregReg[3:0]} - {1'b0, memRdData[3:0]} - {4'h0, ~carryReg};
   assign minus1 = memRdData - 8'h01;
   assign plus1 = memRdData + 8'h01;

   always_comb
   begin
      pcNext = pcReg;
      wregNext = wregReg;
      memWrEnNext = 1'b0;
      memWrAddrNext = memWrAddrReg;
      memWrDataNext = memWrDataReg;
      stackPopNext = 1'b0;
      irqServeNext = 1'b0;
      busyNext = 1'b0;
      wdtClearNext = 1'b0;
      carryNext = carryReg;
      halfNext = halfReg;
      zeroNext = zeroReg;
      excessNext = excessReg;
      irqEnNext = irqEnReg;
      sleepNext = sleepReg && !wake;
      // Timeout event beats any clear in the same cycle
      wdExpNext = wdExpReg || wdtTimeout;
      if (fire)
      begin
         pcNext = pcReg + mie_pkg::PC_STEP;
         memWrAddrNext = memAddr;
         case (instOp)
            mie_pkg::OP_BCD_ADJUST:
            begin
               memWrEnNext = 1'b1;
               memWrDataNext = bcdSum[7:0];
               carryNext = hiAdj || bcdSum[8];
            end
            mie_pkg::OP_MINUS1_MEM:
            begin
               memWrEnNext = 1'b1;
               memWrDataNext = minus1;
               zeroNext = (minus1 == 8'h00);
            end
            mie_pkg::OP_PLUS1_MEM:
            begin
               memWrEnNext = 1'b1;
               memWrDataNext = plus1;
               zeroNext = (plus1 == 8'h00);
            end
            mie_pkg::OP_MINUS1_WREG:
            begin
               wregNext = minus1;
               zeroNext = (minus1 == 8'h00);
            end
            mie_pkg::OP_PLUS1_WREG:
            begin
               wregNext = plus1;
               zeroNext = (plus1 == 8'h00);
            end
            mie_pkg::OP_POWER_DOWN:
            begin
               sleepNext = 1'b1;
               wdExpNext = wdtTimeout;
               wdtClearNext = 1'b1;
            end
            mie_pkg::OP_JUMP_ABS:
            begin
               pcNext = instTarget;
               busyNext = 1'b1;
            end
            mie_pkg::OP_COPY_M2W: wregNext = memRdData;
            mie_pkg::OP_COPY_I2W: wregNext = instImm;
            mie_pkg::OP_COPY_W2M:
            begin
               memWrEnNext = 1'b1;
               memWrDataNext = wregReg;
            end
            mie_pkg::OP_UNION_MEM_W:
            begin
               wregNext = wregReg | memRdData;
               zeroNext = ((wregReg | memRdData) == 8'h00);
            end
            mie_pkg::OP_UNION_IMM_W:
            begin
               wregNext = wregReg | instImm;
               zeroNext = ((wregReg | instImm) == 8'h00);
            end
            mie_pkg::OP_UNION_TO_MEM:
            begin
               memWrEnNext = 1'b1;
               memWrDataNext = wregReg | memRdData;
               zeroNext = ((wregReg | memRdData) == 8'h00);
            end
            mie_pkg::OP_CALL_EXIT, mie_pkg::OP_CALL_EXIT_IMM:
            begin
               pcNext = stackTop;
               stackPopNext = 1'b1;
               busyNext = 1'b1;
               if (instOp == mie_pkg::OP_CALL_EXIT_IMM)
                  wregNext = instImm;
            end
            mie_pkg::OP_IRQ_EXIT:
            begin
               pcNext = stackTop;
               stackPopNext = 1'b1;
               busyNext = 1'b1;
               irqEnNext = 1'b1;
               // Pending request is served before the main program resumes
               irqServeNext = irqPending;
            end
            mie_pkg::OP_ROL_MEM:
            begin
               memWrEnNext = 1'b1;
               memWrDataNext = {memRdData[6:0], memRdData[7]};
            end
            mie_pkg::OP_ROL_WREG: wregNext = {memRdData[6:0], memRdData[7]};
            mie_pkg::OP_ROLC_MEM, mie_pkg::OP_ROLC_WREG:
            begin
               carryNext = memRdData[7];
               if (instOp == mie_pkg::OP_ROLC_MEM)
               begin
                  memWrEnNext = 1'b1;
                  memWrDataNext = {memRdData[6:0], carryReg};
               end
               else
                  wregNext = {memRdData[6:0], carryReg};
            end
            mie_pkg::OP_ROR_MEM:
            begin
               memWrEnNext = 1'b1;
               memWrDataNext = {memRdData[0], memRdData[7:1]};
            end
            mie_pkg::OP_ROR_WREG: wregNext = {memRdData[0], memRdData[7:1]};
            mie_pkg::OP_RORC_MEM, mie_pkg::OP_RORC_WREG:
            begin
               carryNext = memRdData[0];
               if (instOp == mie_pkg::OP_RORC_MEM)
               begin
                  memWrEnNext = 1'b1;
                  memWrDataNext = {carryReg, memRdData[7:1]};
               end
               else
                  wregNext = {carryReg, memRdData[7:1]};
            end
            mie_pkg::OP_SUBB_WREG, mie_pkg::OP_SUBB_MEM:
            begin
               carryNext = !diff9[8];
               halfNext = !diffLo[4];
               zeroNext = (diff9[7:0] == 8'h00);
               excessNext = (wregReg[7] != memRdData[7]) && (diff9[7] != wregReg[7]);
               if (instOp == mie_pkg::OP_SUBB_MEM)
               begin
                  memWrEnNext = 1'b1;
                  memWrDataNext = diff9[7:0];
               end
               else
                  wregNext = diff9[7:0];
            end
            mie_pkg::OP_DSKIP_MEM, mie_pkg::OP_DSKIP_WREG:
            begin
               if (instOp == mie_pkg::OP_DSKIP_MEM)
               begin
                  memWrEnNext = 1'b1;
                  memWrDataNext = minus1;
               end
               else
                  wregNext = minus1;
               if (minus1 == 8'h00)
               begin
                  pcNext = pcReg + mie_pkg::PC_SKIP;
                  busyNext = 1'b1;
               end
            end
            default: pcNext = pcReg + mie_pkg::PC_STEP;
         endcase
      end
      readyNext = ctrlReg[mie_pkg::CTRL_RUN_BIT] && !busyNext && !sleepNext;
   end

   // Frozen while clkEn is low unless sys_rst is high
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         pcReg <= mie_pkg::PC_RESET;
         wregReg <= mie_pkg::WREG_RESET;
         memWrEnReg <= 1'b0;
         memWrAddrReg <= 8'h00;
         memWrDataReg <= 8'h00;
         stackPopReg <= 1'b0;
         irqServeReg <= 1'b0;
         busyReg <= 1'b0;
         wdtClearReg <= 1'b0;
         carryReg <= 1'b0;
         halfReg <= 1'b0;
         zeroReg <= 1'b0;
         excessReg <= 1'b0;
         irqEnReg <= 1'b0;
         sleepReg <= 1'b0;
         wdExpReg <= 1'b0;
         readyReg <= 1'b0;
      end
      else if (clkEn)
      begin
         pcReg <= pcNext;
         wregReg <= wregNext;
         memWrEnReg <= memWrEnNext;
         memWrAddrReg <= memWrAddrNext;
         memWrDataReg <= memWrDataNext;
         stackPopReg <= stackPopNext;
         irqServeReg <= irqServeNext;
         busyReg <= busyNext;
         wdtClearReg <= wdtClearNext;
         carryReg <= carryNext;
         halfReg <= halfNext;
         zeroReg <= zeroNext;
         excessReg <= excessNext;
         irqEnReg <= irqEnNext;
         sleepReg <= sleepNext;
         wdExpReg <= wdExpNext;
         readyReg <= readyNext;
      end
   end

   // APB: one wait state, answer on the second access cycle
   always_comb
   begin
      ctrlNext = ctrlReg;
      prdataNext = prdataReg;
      slverrNext = 1'b0;
      preadyNext = psel && penable && !preadyReg;
      if (psel && penable && !preadyReg)
      begin
         prdataNext = 32'h0000_0000;
         if (paddr == mie_pkg::ADDR_STATUS)
         begin
            prdataNext[mie_pkg::ST_WREG_LSB +: 8] = wregReg;
            prdataNext[mie_pkg::ST_CARRY] = carryReg;
            prdataNext[mie_pkg::ST_HALF] = halfReg;
            prdataNext[mie_pkg::ST_ZERO] = zeroReg;
            prdataNext[mie_pkg::ST_EXCESS] = excessReg;
            prdataNext[mie_pkg::ST_IRQEN] = irqEnReg;
            prdataNext[mie_pkg::ST_SLEEP] = sleepReg;
            prdataNext[mie_pkg::ST_WDEXP] = wdExpReg;
            prdataNext[mie_pkg::ST_PC_LSB +: mie_pkg::PC_W] = pcReg;
         end
         else if (paddr == mie_pkg::ADDR_CTRL)
            prdataNext[mie_pkg::CTRL_RUN_BIT] = ctrlReg[mie_pkg::CTRL_RUN_BIT];
         else
            slverrNext = 1'b1;
      end
      if (apbDone && pwrite && (paddr == mie_pkg::ADDR_CTRL))
         ctrlNext[mie_pkg::CTRL_RUN_BIT] = pwdata[mie_pkg::CTRL_RUN_BIT];
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ctrlReg <= mie_pkg::CTRL_RESET;
         prdataReg <= 32'h0000_0000;
         preadyReg <= 1'b0;
         slverrReg <= 1'b0;
      end
      else if (clkEn)
      begin
         ctrlReg <= ctrlNext;
         prdataReg <= prdataNext;
         preadyReg <= preadyNext;
         slverrReg <= slverrNext;
      end
   end

   assign instReady = readyReg;
   assign pcOut = pcReg;
   assign wregOut = wregReg;
   assign memWrEn = memWrEnReg;
   assign memWrAddr = memWrAddrReg;
   assign memWrData = memWrDataReg;
   assign stackPop = stackPopReg;
   assign irqServe = irqServeReg;
   assign dummySlot = busyReg;
   assign wdtClear = wdtClearReg;
   assign clockStop = sleepReg;
   assign carryFlag = carryReg;
   assign halfCarryFlag = halfReg;
   assign zeroFlag = zeroReg;
   assign signedExcessFlag = excessReg;
   assign masterIrqEnable = irqEnReg;
   assign sleepFlag = sleepReg;
   assign watchdogExpiredFlag = wdExpReg;
   assign prdata = prdataReg;
   assign pready = preadyReg;
   assign pslverr = slverrReg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_bcd_write: assert property (
      fire && instOp == mie_pkg::OP_BCD_ADJUST |=> memWrEnReg
      && memWrDataReg == $past(bcdSum[7:0]) && zeroReg == $past(zeroReg))
      else $error("bcd adjust result wrong");
   a_bcd_nofix: assert property (
      fire && instOp == mie_pkg::OP_BCD_ADJUST && !halfReg && !carryReg
      && wregReg[3:0] < 4'hA && wregReg[7:4] < 4'hA
      |=> memWrDataReg == $past(wregReg) && !carryReg)
      else $error("bcd adjust corrected valid digits");
   a_mem_minus: assert property (
      fire && instOp == mie_pkg::OP_MINUS1_MEM |=> memWrEnReg
      && memWrDataReg == $past(minus1) && zeroReg == (memWrDataReg == 8'h00)
      && carryReg == $past(carryReg))
      else $error("memory decrement wrong");
   a_wreg_plus: assert property (
      fire && instOp == mie_pkg::OP_PLUS1_WREG
      |=> !memWrEnReg && wregReg == $past(plus1))
      else $error("register increment wrong");
   a_power_down: assert property (
      fire && instOp == mie_pkg::OP_POWER_DOWN && !wdtTimeout
      |=> sleepReg && !wdExpReg && wdtClearReg && !readyReg)
      else $error("power down flags wrong");
   a_jump_two: assert property (
      fire && instOp == mie_pkg::OP_JUMP_ABS
      |=> pcReg == $past(instTarget) && busyReg && !readyReg)
      else $error("jump target or dummy wrong");
   a_irq_exit: assert property (
      fire && instOp == mie_pkg::OP_IRQ_EXIT |=> irqEnReg
      && pcReg == $past(stackTop) && irqServeReg == $past(irqPending))
      else $error("interrupt exit wrong");
   a_subb_flags: assert property (
      fire && instOp == mie_pkg::OP_SUBB_WREG |=> wregReg == 8'($past(wregReg)
      - $past(memRdData) - {7'h00, !$past(carryReg)}) && carryReg == ({1'b0, $past(wregReg)}
      >= {1'b0, $past(memRdData)} + {8'h00, !$past(carryReg)}))
      else $error("subtract with borrow wrong");
   a_skip_taken: assert property (
      fire && instOp == mie_pkg::OP_DSKIP_MEM && memRdData == 8'h01
      |=> pcReg == $past(pcReg) + mie_pkg::PC_SKIP && busyReg)
      else $error("skip not taken");
   a_rotate_left: assert property (
      fire && instOp == mie_pkg::OP_ROL_WREG |=> !memWrEnReg
      && wregReg == {$past(memRdData[6:0]), $past(memRdData[7])})
      else $error("left rotate wrong");

   c_power_down: cover property (fire && instOp == mie_pkg::OP_POWER_DOWN);
   c_jump: cover property (fire && instOp == mie_pkg::OP_JUMP_ABS ##1 busyReg);
   c_skip: cover property (fire && instOp == mie_pkg::OP_DSKIP_WREG && minus1 == 8'h00);

endmodule : mie_execute_core

// >>> testbench/mie_mem_model.sv
// Data memory and return stack that face the execute core.
// Assumes write and pop strobes last one cycle on clk_sys; the bench presets contents.
`timescale 1ns/1ps
module mie_mem_model (
   // Clock
   input wire logic clk_sys,
   // Data memory
   input wire logic [7:0] memAddr,
   output logic [7:0] memRdData,
   input wire logic memWrEn,
   input wire logic [7:0] memWrAddr,
   input wire logic [7:0] memWrData,
   // Return stack
   input wire logic stackPop,
   output logic [mie_pkg::PC_W-1:0] stackTop
);
   logic [7:0] mem [256];
   logic [mie_pkg::PC_W-1:0] stk [4];
   logic [1:0] sp = 2'h0;
   // Operand must be on the bus in the offer cycle itself
   assign memRdData = mem[memAddr];
   assign stackTop = stk[sp];
   always @(posedge clk_sys)
   begin
      if (memWrEn)
         mem[memWrAddr] <= memWrData;
      if (stackPop)
         sp <= sp - 2'h1;
   end
endmodule : mie_mem_model

// >>> testbench/mie_execute_core_tb.sv
// Self-checking bench for the execute core, with memory and stack model.
// Assumes the one-cycle answer and one-wait-state APB timing of the core.
`timescale 1ns/1ps
module mie_execute_core_tb;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic instValid = 1'b0;
   mie_pkg::mie_op_e instOp = mie_pkg::OP_IDLE;
   logic [7:0] instImm = 8'h00;
   logic [10:0] instTarget = 11'h2A5;
   logic [7:0] memAddr = 8'h00;
   logic irqPending = 1'b0;
   logic wdtTimeout = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [7:0] memRdData, wregOut, memWrAddr, memWrData;
   logic [10:0] pcOut, stackTop, pc0;
   logic instReady, memWrEn, stackPop, irqServe, dummySlot, wdtClear, clockStop, pready;
   logic carryFlag, halfCarryFlag, zeroFlag, signedExcessFlag, masterIrqEnable, sleepFlag;
   logic watchdogExpiredFlag, pslverr;
   logic [3:0] flg;
   logic [7:0] rin [8] = '{8'h42, 8'h42, 8'h42, 8'h42, 8'h42, 8'h42, 8'h43, 8'h42};
   logic [7:0] rexp [8] = '{8'h84, 8'h84, 8'h85, 8'h84, 8'h21, 8'h21, 8'h21, 8'hA1};
   logic [7:0] rc = 8'b01000011;
   int errorCnt = 0;
   int checked = 0;
   assign flg = {carryFlag, halfCarryFlag, zeroFlag, signedExcessFlag};
   always #2.5 clk_sys = ~clk_sys;
   mie_execute_core mie_execute_core_i (.clk_sys, .sys_rst, .clkEn(1'b1), .instValid, .instOp,
      .instImm, .instTarget, .memAddr, .memRdData, .stackTop, .irqPending, .wdtTimeout,
      .instReady, .pcOut, .wregOut, .memWrEn, .memWrAddr, .memWrData, .stackPop, .irqServe,
      .dummySlot, .wdtClear, .clockStop, .carryFlag, .halfCarryFlag, .zeroFlag,
      .signedExcessFlag, .masterIrqEnable, .sleepFlag, .watchdogExpiredFlag, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   mie_mem_model mdl_i (.clk_sys, .memAddr, .memRdData, .memWrEn, .memWrAddr, .memWrData,
      .stackPop, .stackTop);
   // Wide enough for the error bit beside a full read word
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Offer held until the edge that sees instReady, then released
   task automatic exec(input mie_pkg::mie_op_e op, input logic [7:0] a, input logic [7:0] imm);
      int n;
      @(posedge clk_sys);
      instValid <= 1'b1;
      instOp <= op;
      memAddr <= a;
      instImm <= imm;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (instReady !== 1'b1 && n < 50);
      if (instReady !== 1'b1)
         errorCnt++;
      instValid <= 1'b0;
      pc0 = pcOut;
      #1;
   endtask : exec
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         errorCnt++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, errorCnt);
      if (errorCnt == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      errorCnt++;
      final_report();
   end
   initial
   begin
      mdl_i.stk[0] = 11'h123;
      mdl_i.stk[3] = 11'h0AB;
      mdl_i.stk[2] = 11'h055;
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      apb(1'b0, mie_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, 12'h008, 32'h0);
      chk({er, rd}, 33'h100000000);
      $display("test reset and bus done");
      mdl_i.mem[16] = 8'h00;
      exec(mie_pkg::OP_COPY_I2W, 8'h00, 8'h7B);
      chk({wregOut, flg}, 12'h7B0);
      exec(mie_pkg::OP_BCD_ADJUST, 8'h10, 8'h00);
      chk({memWrEn, memWrAddr, memWrData, flg}, 21'h110810);
      exec(mie_pkg::OP_COPY_I2W, 8'h00, 8'hA5);
      exec(mie_pkg::OP_BCD_ADJUST, 8'h10, 8'h00);
      chk({memWrData, flg}, 12'h058);
      $display("test decimal adjust done");
      for (int i = 0; i < 8; i++)
      begin
         // Own byte per step: the previous write lands one edge late
         mdl_i.mem[32 + i] = rin[i];
         exec(mie_pkg::mie_op_e'(5'h11 + i), 8'(32 + i), 8'h00);
         chk({i[0] ? wregOut : memWrData, memWrEn, carryFlag}, {rexp[i], ~i[0], rc[i]});
      end
      $display("test rotates done");
      mdl_i.mem[48] = 8'h01;
      mdl_i.mem[49] = 8'hFF;
      exec(mie_pkg::OP_MINUS1_MEM, 8'h30, 8'h00);
      chk({memWrEn, memWrData, zeroFlag}, 10'h201);
      exec(mie_pkg::OP_PLUS1_WREG, 8'h30, 8'h00);
      chk({memWrEn, wregOut, zeroFlag}, 10'h002);
      exec(mie_pkg::OP_MINUS1_WREG, 8'h30, 8'h00);
      chk({memWrEn, wregOut, zeroFlag}, 10'h1FE);
      exec(mie_pkg::OP_PLUS1_MEM, 8'h31, 8'h00);
      chk({memWrEn, memWrData, zeroFlag}, 10'h201);
      mdl_i.mem[64] = 8'h5A;
      mdl_i.mem[65] = 8'hA5;
      exec(mie_pkg::OP_COPY_I2W, 8'h00, 8'h00);
      exec(mie_pkg::OP_UNION_IMM_W, 8'h00, 8'h00);
      chk({wregOut, zeroFlag}, 9'h001);
      exec(mie_pkg::OP_UNION_MEM_W, 8'h40, 8'h00);
      chk({wregOut, zeroFlag}, 9'h0B4);
      exec(mie_pkg::OP_UNION_TO_MEM, 8'h41, 8'h00);
      chk({memWrEn, memWrData, wregOut, flg}, 21'h1FF5A0);
      $display("test step and union done");
      mdl_i.mem[80] = 8'h20;
      mdl_i.mem[81] = 8'h01;
      exec(mie_pkg::OP_COPY_I2W, 8'h00, 8'h10);
      exec(mie_pkg::OP_SUBB_WREG, 8'h50, 8'h00);
      chk({wregOut, flg}, 12'hEF0);
      exec(mie_pkg::OP_SUBB_MEM, 8'h50, 8'h00);
      chk({memWrEn, memWrData, flg}, 13'h1CEC);
      exec(mie_pkg::OP_COPY_I2W, 8'h00, 8'h80);
      exec(mie_pkg::OP_SUBB_WREG, 8'h51, 8'h00);
      chk({wregOut, flg}, 12'h7F9);
      $display("test subtract done");
      exec(mie_pkg::OP_JUMP_ABS, 8'h00, 8'h00);
      chk({pcOut, dummySlot, instReady, flg}, {11'h2A5, 2'b10, 4'h9});
      @(posedge clk_sys);
      #1;
      chk({dummySlot, instReady}, 2'b01);
      mdl_i.mem[96] = 8'h01;
      mdl_i.mem[97] = 8'h05;
      mdl_i.mem[98] = 8'h01;
      exec(mie_pkg::OP_DSKIP_MEM, 8'h60, 8'h00);
      chk({pcOut, dummySlot, memWrData, flg}, {pc0 + 11'h2, 9'h100, 4'h9});
      exec(mie_pkg::OP_DSKIP_WREG, 8'h61, 8'h00);
      chk({pcOut, dummySlot, memWrEn, wregOut}, {pc0 + 11'h1, 10'h004});
      chk(mdl_i.mem[96], 8'h00);
      exec(mie_pkg::OP_DSKIP_WREG, 8'h62, 8'h00);
      chk({pcOut, dummySlot, memWrEn, wregOut}, {pc0 + 11'h2, 10'h200});
      exec(mie_pkg::OP_IDLE, 8'h00, 8'h00);
      chk({pcOut, memWrEn, wregOut, flg}, {pc0 + 11'h1, 13'h0009});
      $display("test flow done");
      exec(mie_pkg::OP_CALL_EXIT, 8'h00, 8'h00);
      chk({pcOut, stackPop, flg}, {11'h123, 5'h19});
      exec(mie_pkg::OP_CALL_EXIT_IMM, 8'h00, 8'h77);
      chk({pcOut, wregOut, flg}, {11'h0AB, 12'h779});
      @(posedge clk_sys);
      irqPending <= 1'b1;
      exec(mie_pkg::OP_IRQ_EXIT, 8'h00, 8'h00);
      chk({pcOut, masterIrqEnable, irqServe, stackPop}, {11'h055, 3'b111});
      $display("test exits done");
      @(posedge clk_sys);
      wdtTimeout <= 1'b1;
      @(posedge clk_sys);
      wdtTimeout <= 1'b0;
      #1;
      chk(watchdogExpiredFlag, 1'b1);
      exec(mie_pkg::OP_POWER_DOWN, 8'h00, 8'h00);
      chk({sleepFlag, watchdogExpiredFlag, wdtClear, clockStop}, 4'b1011);
      @(posedge clk_sys);
      #1;
      chk({instReady, wregOut, flg}, 13'h0779);
      apb(1'b1, mie_pkg::ADDR_CTRL, 32'h3);
      apb(1'b0, mie_pkg::ADDR_STATUS, 32'h0);
      chk({er, rd[14:12], rd[7:0]}, 12'h177);
      $display("test power down done");
      final_report();
   end
endmodule : mie_execute_core_tb
